// [design/pms_pkg.sv]
package pms_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  // System clock rate in hertz (period 50 ns).
  localparam int unsigned CLK_HZ          = 20_000_000;
  // Least run-indicator blink time after start-up begins, in seconds.
  localparam int unsigned BLINK_MIN_S     = 3;
  // Least blink time as a cycle count; a plain product, so exact here.
  localparam int unsigned BLINK_MIN_CYC   = BLINK_MIN_S * CLK_HZ;
  // Half period of the indicator blink, in milliseconds.
  localparam int unsigned BLINK_HALF_MS   = 250;
  // Blink half period as a cycle count; dividing first keeps it within 32 bits.
  localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1000);

  // ---------------------------------------------------------------
  // Breakpoints
  // ---------------------------------------------------------------
  // Most breakpoints that may be defined at once.
  localparam int unsigned BP_MAX          = 3;
  // Above this many defined breakpoints single-step is refused.
  localparam logic [1:0]  BP_STEP_LIMIT   = 2'h2;

  // ---------------------------------------------------------------
  // APB register map (byte addresses)
  // ---------------------------------------------------------------
  // Control: mode and debug requests, write only pulses.
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  // Status: mode, indicators, inhibit, flags.
  localparam logic [7:0]  REG_STATUS      = 8'h04;
  // Breakpoint defined and active bits.
  localparam logic [7:0]  REG_BP_CFG      = 8'h08;
  // Breakpoint n address at REG_BP_ADDR0 + 4*n.
  localparam logic [7:0]  REG_BP_ADDR0    = 8'h0c;
  // Statement counter of the program engine, read only.
  localparam logic [7:0]  REG_PC          = 8'h18;
  // Cycle count of completed main cycles, read only.
  localparam logic [7:0]  REG_CYCLES      = 8'h1c;

  // Control register bit positions.
  localparam int unsigned CTRL_RUN_REQ    = 0;
  localparam int unsigned CTRL_STOP_REQ   = 1;
  localparam int unsigned CTRL_STEP_REQ   = 2;
  localparam int unsigned CTRL_RESUME_REQ = 3;
  localparam int unsigned CTRL_CLR_BP     = 4;
  localparam int unsigned CTRL_CLR_REFUSE = 5;

  // Status register bit positions.
  localparam int unsigned ST_MODE_LSB     = 0;
  localparam int unsigned ST_INHIBIT      = 4;
  localparam int unsigned ST_RUN_IND      = 5;
  localparam int unsigned ST_STOP_IND     = 6;
  localparam int unsigned ST_STEP_REFUSED = 7;
  localparam int unsigned ST_BLINKING     = 8;

  // Breakpoint config register field positions.
  localparam int unsigned BPC_DEF_LSB     = 0;
  localparam int unsigned BPC_ACT_LSB     = 4;

  // Reset values.
  localparam logic [15:0] BP_ADDR_RST     = 16'h0000;

  // ---------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PMS_STOP    = 2'b00,
    PMS_STARTUP = 2'b01,
    PMS_RUN     = 2'b10,
    PMS_HOLD    = 2'b11
  } pms_mode_t;

  // Phases of the start-up sequence and of each run cycle.
  typedef enum logic [2:0] {
    PH_IDLE     = 3'b000,
    PH_CLR_IN   = 3'b001,
    PH_STARTUP  = 3'b010,
    PH_CLR_OUT  = 3'b011,
    PH_READ_IN  = 3'b100,
    PH_EXEC     = 3'b101,
    PH_WRITE    = 3'b110
  } pms_phase_t;

endpackage : pms_pkg

// [design/pms_sequencer.sv]
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Exactly one of four modes held.
// - Stop mode runs no user program.
// - Entering stop keeps images and timers.
// - Stop: inhibit on, run off, stop lit; run still blinks here until the 3s blink window ends.
// - Stop to run enters start-up, unsupervised.
// - Start-up: inhibit on, stop indicator off.
// - Run indicator blinks at least 3s.
// - Start-up routine done moves to run.
// - Run repeats main cycle routine continually.
// - Run: timers advance, image refreshed each cycle.
// - Run: inhibit off, run lit, stop off; run still blinks here until the 3s blink window ends.
// - At most three breakpoints, tool manages them.
// - Active breakpoint hit enters hold, reports.
// - Hold: run blinks, stop lit steadily.
// - Hold freezes execution and timers, clock runs.
// - Hold keeps output inhibit asserted.
// - Hold keeps comm processor links up.
// - Step runs one statement; resume to breakpoint.
// - Step refused with more than two breakpoints.
// - Breakpoints work without test mode.
// - Start-up order: clear inputs, routine, outputs.
// - Cycle order: read, execute, write images.
module pms_sequencer (
  // Clock, reset and clock enable
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        clk_en,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic        [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // Program engine (same clock domain)
  input  wire  logic [15:0] stmt_addr,
  input  wire  logic        stmt_done,
  input  wire  logic        startup_done,
  input  wire  logic        cycle_done,
  input  wire  logic        fault_stop,
  output logic              startup_routine,
  output logic              main_cycle_routine,
  output logic              exec_enable,
  output logic              timer_enable,
  output logic              input_image_clear,
  output logic              output_image_clear,
  output logic              input_image_read,
  output logic              output_image_write,
  output logic              regs_report,
  // Plant side
  output logic              output_inhibit,
  output logic              run_indicator,
  output logic              stop_indicator,
  output logic              comm_processor_keep,
  output logic              rtc_enable
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    pms_pkg::pms_mode_t  mode;         // Current operating mode.
    pms_pkg::pms_phase_t phase;        // Sequence phase.
    logic [2:0]          bp_def;       // Breakpoint defined bits.
    logic [2:0]          bp_act;       // Breakpoint active bits.
    logic [47:0]         bp_addr;      // Three 16-bit addresses.
    logic                step_pend;    // One statement granted.
    logic                skip_bp;      // Ignore breakpoint once on leaving hold.
    logic                refused;      // Sticky step-refused flag.
    logic [25:0]         blink_hold;   // Least-blink countdown.
    logic [22:0]         blink_div;    // Blink half-period counter.
    logic                blink_ph;     // Blink phase.
    logic [31:0]         cycles;       // Completed main cycles.
    logic [31:0]         prdata;       // Read data register.
    logic                pready;       // Access phase answer.
    logic                pslverr;      // Error answer.
    logic                inhibit;      // Output inhibit.
    logic                run_ind;      // Run indicator.
    logic                stop_ind;     // Stop indicator.
    logic                su_rt;        // Start-up routine call.
    logic                mc_rt;        // Main cycle call.
    logic                exec_en;      // Statement execution enable.
    logic                tmr_en;       // Program timer enable.
    logic                in_clr;       // Input image clear pulse.
    logic                out_clr;      // Output image clear pulse.
    logic                in_rd;        // Input image read pulse.
    logic                out_wr;       // Output image write pulse.
    logic                report;       // Register report pulse.
    logic                links;        // Comm links and real-time clock kept up.
  } pms_state_t;

  pms_state_t state;       // Registered state.
  pms_state_t next_state;  // Next state.
  // Counts the defined breakpoints.
  function automatic logic [1:0] pms_count3(input logic [2:0] v);
    pms_count3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction : pms_count3
  // True when the statement address matches a breakpoint that is both defined and active.
  function automatic logic pms_bp_hit(input logic [2:0] act, input logic [2:0] def,
                                      input logic [47:0] addr, input logic [15:0] a);
    pms_bp_hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (act[i] && def[i] && addr[i*16 +: 16] == a) begin
        pms_bp_hit = 1'b1;
      end
    end
  endfunction : pms_bp_hit

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // Bus, mode sequencing and indicators are all decided here.
  always_comb begin
    logic        wr;
    logic        rd;
    logic [31:0] ctl;
    logic        hit;
    logic        run_req;
    logic        stop_req;
    logic        step_req;
    logic        resume_req;
    wr         = 1'b0;
    rd         = 1'b0;
    ctl        = 32'h0000_0000;
    hit        = 1'b0;
    run_req    = 1'b0;
    stop_req   = 1'b0;
    step_req   = 1'b0;
    resume_req = 1'b0;
    next_state = state;
    next_state.in_clr  = 1'b0;
    next_state.out_clr = 1'b0;
    next_state.in_rd   = 1'b0;
    next_state.out_wr  = 1'b0;
    next_state.report  = 1'b0;
    next_state.pready  = 1'b0;
    next_state.pslverr = 1'b0;
    // APB: one wait state, answer registered in the access phase.
    wr = psel && penable && !state.pready && pwrite;
    rd = psel && penable && !state.pready && !pwrite;
    if (psel && penable && !state.pready) begin
      next_state.pready = 1'b1;
    end
    if (wr && paddr == pms_pkg::REG_CTRL) begin
      ctl = pwdata;
    end else if (wr && paddr == pms_pkg::REG_BP_CFG) begin
      next_state.bp_def = pwdata[pms_pkg::BPC_DEF_LSB +: 3];
      next_state.bp_act = pwdata[pms_pkg::BPC_ACT_LSB +: 3];
    end else if (wr && paddr >= pms_pkg::REG_BP_ADDR0 && paddr < pms_pkg::REG_PC
                 && paddr[1:0] == 2'b00) begin
      next_state.bp_addr[((paddr - pms_pkg::REG_BP_ADDR0) >> 2) * 16 +: 16] = pwdata[15:0];
    end else if (wr && paddr != pms_pkg::REG_STATUS && paddr != pms_pkg::REG_CYCLES) begin
      // Unmapped writes answer with an error; read-only writes are ignored.
      if (paddr != pms_pkg::REG_PC) begin
        next_state.pslverr = 1'b1;
      end
    end
    if (rd) begin
      if (paddr == pms_pkg::REG_CTRL) begin
        next_state.prdata = 32'h0000_0000;
      end else if (paddr == pms_pkg::REG_STATUS) begin
        next_state.prdata = {23'h000000, (state.blink_hold != 26'h0000000), state.refused,
                             state.stop_ind, state.run_ind, state.inhibit,
                             2'h0, state.mode};
      end else if (paddr == pms_pkg::REG_BP_CFG) begin
        next_state.prdata = {25'h0000000, state.bp_act, 1'b0, state.bp_def};
      end else if (paddr == pms_pkg::REG_BP_ADDR0) begin
        next_state.prdata = {16'h0000, state.bp_addr[15:0]};
      end else if (paddr == pms_pkg::REG_BP_ADDR0 + 8'h04) begin
        next_state.prdata = {16'h0000, state.bp_addr[31:16]};
      end else if (paddr == pms_pkg::REG_BP_ADDR0 + 8'h08) begin
        next_state.prdata = {16'h0000, state.bp_addr[47:32]};
      end else if (paddr == pms_pkg::REG_PC) begin
        next_state.prdata = {16'h0000, stmt_addr};
      end else if (paddr == pms_pkg::REG_CYCLES) begin
        next_state.prdata = state.cycles;
      end else begin
        next_state.prdata  = 32'h0000_0000;
        next_state.pslverr = 1'b1;
      end
    end

    run_req    = ctl[pms_pkg::CTRL_RUN_REQ];
    stop_req   = ctl[pms_pkg::CTRL_STOP_REQ] || fault_stop;
    step_req   = ctl[pms_pkg::CTRL_STEP_REQ];
    resume_req = ctl[pms_pkg::CTRL_RESUME_REQ];
    if (ctl[pms_pkg::CTRL_CLR_BP]) begin
      next_state.bp_def = 3'h0;
      next_state.bp_act = 3'h0;
    end
    if (ctl[pms_pkg::CTRL_CLR_REFUSE]) begin
      next_state.refused = 1'b0;
    end
    hit = pms_bp_hit(state.bp_act, state.bp_def, state.bp_addr, stmt_addr)
          && !state.skip_bp;
    // Blink timers run independently of the mode.
    if (state.blink_hold != 26'h0000000) begin
      next_state.blink_hold = state.blink_hold - 26'h0000001;
    end
    if (state.blink_div == 23'(pms_pkg::BLINK_HALF_CYC - 1)) begin
      next_state.blink_div = 23'h000000;
      next_state.blink_ph  = !state.blink_ph;
    end else begin
      next_state.blink_div = state.blink_div + 23'h000001;
    end

    case (state.mode)
      pms_pkg::PMS_STOP: begin
        next_state.phase = pms_pkg::PH_IDLE;
        if (run_req && !fault_stop) begin
          next_state.mode  = pms_pkg::PMS_STARTUP;
          next_state.phase = pms_pkg::PH_CLR_IN;
          next_state.blink_hold = 26'(pms_pkg::BLINK_MIN_CYC);
        end
      end
      pms_pkg::PMS_STARTUP: begin
        case (state.phase)
          pms_pkg::PH_CLR_IN: begin
            next_state.in_clr = 1'b1;
            next_state.phase  = pms_pkg::PH_STARTUP;
          end
          pms_pkg::PH_STARTUP: begin
            if (startup_done) begin
              next_state.mode    = pms_pkg::PMS_RUN;
              next_state.phase   = pms_pkg::PH_CLR_OUT;
              next_state.out_clr = 1'b1;
            end
          end
          default: begin
            next_state.phase = pms_pkg::PH_CLR_IN;
          end
        endcase
        if (stop_req) begin
          next_state.mode  = pms_pkg::PMS_STOP;
          next_state.phase = pms_pkg::PH_IDLE;
        end
      end
      pms_pkg::PMS_RUN: begin
        case (state.phase)
          pms_pkg::PH_CLR_OUT, pms_pkg::PH_WRITE: begin
            next_state.in_rd = 1'b1;
            next_state.phase = pms_pkg::PH_READ_IN;
          end
          pms_pkg::PH_READ_IN: begin
            next_state.phase = pms_pkg::PH_EXEC;
          end
          pms_pkg::PH_EXEC: begin
            if (stmt_done) begin
              next_state.skip_bp = 1'b0;
            end
            if (cycle_done) begin
              next_state.out_wr = 1'b1;
              next_state.phase  = pms_pkg::PH_WRITE;
              next_state.cycles = state.cycles + 32'h0000_0001;
            end
          end
          default: begin
            next_state.phase = pms_pkg::PH_READ_IN;
            next_state.in_rd = 1'b1;
          end
        endcase
        if (state.step_pend && stmt_done) begin
          next_state.step_pend = 1'b0;
          next_state.mode      = pms_pkg::PMS_HOLD;
          next_state.report    = 1'b1;
        end else if (state.phase == pms_pkg::PH_EXEC && hit) begin
          next_state.mode   = pms_pkg::PMS_HOLD;
          next_state.report = 1'b1;
        end
        if (stop_req) begin
          next_state.mode      = pms_pkg::PMS_STOP;
          next_state.step_pend = 1'b0;
        end
      end
      pms_pkg::PMS_HOLD: begin
        if (step_req) begin
          if (pms_count3(state.bp_def) > pms_pkg::BP_STEP_LIMIT) begin
            next_state.refused = 1'b1;
          end else begin
            next_state.step_pend = 1'b1;
            next_state.skip_bp   = 1'b1;
            next_state.mode      = pms_pkg::PMS_RUN;
          end
        end else if (resume_req) begin
          next_state.skip_bp = 1'b1;
          next_state.mode    = pms_pkg::PMS_RUN;
        end
        if (stop_req) begin
          next_state.mode      = pms_pkg::PMS_STOP;
          next_state.step_pend = 1'b0;
        end
      end
      default: begin
        next_state.mode = pms_pkg::PMS_STOP;
      end
    endcase

    // Outputs follow the next mode so each comes from a flip-flop.
    next_state.su_rt   = next_state.mode == pms_pkg::PMS_STARTUP
                         && next_state.phase == pms_pkg::PH_STARTUP && !next_state.in_clr;
    next_state.mc_rt   = next_state.mode == pms_pkg::PMS_RUN
                         && next_state.phase == pms_pkg::PH_EXEC;
    next_state.exec_en = next_state.su_rt || next_state.mc_rt;
    next_state.tmr_en  = next_state.mode == pms_pkg::PMS_RUN;
    next_state.links   = 1'b1;
    next_state.inhibit = next_state.mode != pms_pkg::PMS_RUN;
    case (next_state.mode)
      pms_pkg::PMS_STOP: begin
        // The blink window outlives a fault stop.
        next_state.run_ind  = (next_state.blink_hold != 26'h0000000) && next_state.blink_ph;
        next_state.stop_ind = 1'b1;
      end
      pms_pkg::PMS_STARTUP: begin
        next_state.run_ind  = next_state.blink_ph;
        next_state.stop_ind = 1'b0;
      end
      pms_pkg::PMS_RUN: begin
        next_state.run_ind  = (next_state.blink_hold != 26'h0000000) ? next_state.blink_ph
                                                                       : 1'b1;
        next_state.stop_ind = 1'b0;
      end
      default: begin
        next_state.run_ind  = next_state.blink_ph;
        next_state.stop_ind = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset into stop with inhibit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= '0;
      state.mode     <= pms_pkg::PMS_STOP;
      state.phase    <= pms_pkg::PH_IDLE;
      state.bp_addr  <= {3{pms_pkg::BP_ADDR_RST}};
      state.inhibit  <= 1'b1;
      state.stop_ind <= 1'b1;
      state.links    <= 1'b1;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata              = state.prdata;
  assign pready              = state.pready;
  assign pslverr             = state.pslverr;
  assign startup_routine     = state.su_rt;
  assign main_cycle_routine  = state.mc_rt;
  assign exec_enable         = state.exec_en;
  assign timer_enable        = state.tmr_en;
  assign input_image_clear   = state.in_clr;
  assign output_image_clear  = state.out_clr;
  assign input_image_read    = state.in_rd;
  assign output_image_write  = state.out_wr;
  assign regs_report         = state.report;
  assign output_inhibit      = state.inhibit;
  assign run_indicator       = state.run_ind;
  assign stop_indicator      = state.stop_ind;
  assign comm_processor_keep = state.links;
  assign rtc_enable          = state.links;

endmodule : pms_sequencer

`default_nettype wire

// [tb/pms_sequencer_chk.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the mode sequencer.
// ----------------------------------------------------------------
module pms_sequencer_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Program engine controls.
  input wire logic exec_enable,
  input wire logic timer_enable,
  input wire logic startup_routine,
  input wire logic main_cycle_routine,
  input wire logic input_image_clear,
  input wire logic output_image_clear,
  input wire logic input_image_read,
  input wire logic output_image_write,
  input wire logic regs_report,
  // Plant side.
  input wire logic output_inhibit,
  input wire logic run_indicator,
  input wire logic stop_indicator,
  input wire logic comm_processor_keep,
  input wire logic rtc_enable
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_reset;
    $rose(presetn) |-> output_inhibit && stop_indicator && !run_indicator;
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  property p_run_out;
    timer_enable |-> !output_inhibit && !stop_indicator;
  endproperty
  a_run_out: assert property (p_run_out) else $error("run outputs wrong");
  property p_startup;
    startup_routine |-> output_inhibit && !stop_indicator;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up outputs wrong");
  property p_halted;
    stop_indicator |-> !exec_enable && !timer_enable && output_inhibit;
  endproperty
  a_halted: assert property (p_halted) else $error("halted yet active");
  property p_clr_first;
    input_image_clear |-> !startup_routine ##[1:3] startup_routine;
  endproperty
  a_clr_first: assert property (p_clr_first) else $error("no start-up after clear");
  property p_out_clr;
    output_image_clear |-> ##[1:4] input_image_read;
  endproperty
  a_out_clr: assert property (p_out_clr) else $error("no input read after clear");
  property p_write;
    output_image_write |-> ##1 (input_image_read || output_inhibit);
  endproperty
  a_write: assert property (p_write) else $error("no read after write");
  property p_read_exec;
    input_image_read |-> ##[1:4] main_cycle_routine;
  endproperty
  a_read_exec: assert property (p_read_exec) else $error("no execute after read");
  property p_hold_rep;
    regs_report |-> ##[0:2] (stop_indicator && !exec_enable);
  endproperty
  a_hold_rep: assert property (p_hold_rep) else $error("report without hold");
  property p_keep;
    comm_processor_keep && rtc_enable;
  endproperty
  a_keep: assert property (p_keep) else $error("links or clock dropped");
  c_startup: cover property ($rose(startup_routine));
  c_hold: cover property (regs_report);
  c_cycle: cover property ($fell(main_cycle_routine));
endmodule : pms_sequencer_chk
bind pms_sequencer pms_sequencer_chk u_chk (.pclk(pclk), .presetn(presetn),
  .exec_enable(exec_enable), .timer_enable(timer_enable),
  .startup_routine(startup_routine), .main_cycle_routine(main_cycle_routine),
  .input_image_clear(input_image_clear), .output_image_clear(output_image_clear),
  .input_image_read(input_image_read), .regs_report(regs_report),
  .output_image_write(output_image_write),
  .output_inhibit(output_inhibit), .run_indicator(run_indicator),
  .stop_indicator(stop_indicator), .comm_processor_keep(comm_processor_keep),
  .rtc_enable(rtc_enable));
`default_nettype wire

// [tb/pms_engine_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Program engine model: four statements a cycle.
// ----------------------------------------------------------------
module pms_engine_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Cycles per statement; one is prompt, more is slow.
  input  wire logic [3:0]  gap,
  // Requests from the sequencer.
  input  wire logic        startup_routine,
  input  wire logic        main_cycle_routine,
  input  wire logic        exec_enable,
  // Answers to the sequencer.
  output logic      [15:0] stmt_addr,
  output logic             stmt_done,
  output logic             startup_done,
  output logic             cycle_done
);
  logic [7:0] cnt; // Cycles spent on the current job.
  // Start-up takes 40 cycles; statements advance only while enabled.
  always_ff @(posedge pclk or negedge presetn) begin
    stmt_done <= 1'b0;
    startup_done <= 1'b0;
    cycle_done <= 1'b0;
    if (!presetn) begin
      cnt <= 8'h00;
      stmt_addr <= 16'h0000;
    end else if (startup_routine && !startup_done) begin
      cnt <= (cnt == 8'h27) ? 8'h00 : cnt + 8'h01;
      startup_done <= (cnt == 8'h27);
    end else if (main_cycle_routine && exec_enable) begin
      cnt <= cnt + 8'h01;
      if (cnt + 8'h01 >= {4'h0, gap}) begin
        cnt <= 8'h00;
        stmt_done <= 1'b1;
        cycle_done <= (stmt_addr == 16'h0003);
        stmt_addr <= (stmt_addr == 16'h0003) ? 16'h0000 : stmt_addr + 16'h0001;
      end
    end
  end
endmodule : pms_engine_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (x)); end end
`define WAIT(c) while (!(c)) @(posedge pclk);
module testbench;
  // ----------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] stmt_addr;
  logic        stmt_done, startup_done, cycle_done, startup_routine;
  logic        main_cycle_routine, exec_enable, timer_enable, regs_report;
  logic        stop_indicator;
  logic [3:0]  gap;
  int          mismatches;
  int          compares;
  // Run indicator blinks, so status compares hide bit 5.
  localparam logic [31:0] M = 32'hffffffdf;
  localparam logic [31:0] A = 32'hffffffff;
  pms_sequencer dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stmt_addr(stmt_addr), .stmt_done(stmt_done),
    .startup_done(startup_done), .cycle_done(cycle_done), .fault_stop(1'b0),
    .startup_routine(startup_routine), .main_cycle_routine(main_cycle_routine),
    .exec_enable(exec_enable), .timer_enable(timer_enable), .input_image_clear(),
    .output_image_clear(), .input_image_read(), .output_image_write(),
    .regs_report(regs_report), .output_inhibit(), .run_indicator(),
    .stop_indicator(stop_indicator), .comm_processor_keep(), .rtc_enable());
  pms_engine_model u_eng (.pclk(pclk), .presetn(presetn), .gap(gap),
    .startup_routine(startup_routine), .main_cycle_routine(main_cycle_routine),
    .exec_enable(exec_enable), .stmt_addr(stmt_addr), .stmt_done(stmt_done),
    .startup_done(startup_done), .cycle_done(cycle_done));
  // ----------------------------------------------------------------
  // Bus tasks.
  // ----------------------------------------------------------------
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    `CHK(r & m, x)
  endtask : rd
  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Clock, watchdog and tests.
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    gap = 4'h1;
    mismatches = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h04, A, 32'h00000050);
    rd(8'h08, A, 32'h00000000);
    apb(1'b1, 8'h04, 32'h00000003);
    rd(8'h04, A, 32'h00000050);
    apb(1'b0, 8'h20, 32'h00000000);
    `CHK(e, 1'b1)
    apb(1'b1, 8'h00, 32'h00000001);
    rd(8'h04, M, 32'h00000111);
    `WAIT(timer_enable === 1'b1)
    rd(8'h04, M, 32'h00000102);
    gap <= 4'h4;
    apb(1'b1, 8'h0c, 32'h00000002);
    apb(1'b1, 8'h08, 32'h00000011);
    rd(8'h08, 32'h00000077, 32'h00000011);
    `WAIT(regs_report === 1'b1)
    rd(8'h04, M, 32'h00000153);
    repeat (20) @(posedge pclk);
    rd(8'h18, A, 32'h00000002);
    apb(1'b1, 8'h00, 32'h00000004);
    `WAIT(stmt_done === 1'b1)
    `WAIT(stop_indicator === 1'b1)
    rd(8'h18, A, 32'h00000003);
    apb(1'b1, 8'h08, 32'h00000007);
    apb(1'b1, 8'h00, 32'h00000004);
    rd(8'h04, M, 32'h000001d3);
    rd(8'h18, A, 32'h00000003);
    apb(1'b1, 8'h00, 32'h00000020);
    rd(8'h04, M, 32'h00000153);
    apb(1'b1, 8'h08, 32'h00000011);
    apb(1'b1, 8'h00, 32'h00000008);
    `WAIT(timer_enable === 1'b1)
    rd(8'h04, M, 32'h00000102);
    `WAIT(regs_report === 1'b1)
    rd(8'h18, A, 32'h00000002);
    apb(1'b1, 8'h00, 32'h00000010);
    rd(8'h08, A, 32'h00000000);
    apb(1'b1, 8'h00, 32'h00000002);
    rd(8'h04, M, 32'h00000150);
    rd(8'h18, A, 32'h00000002);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
